/* logic/duc_pkg.sv */
package duc_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int DUC_CH = 8;
	localparam int DUC_W = 14;
	localparam int DUC_AW = 5;
	localparam int DUC_CHW = 3;

	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [4:0] ADR_CONFIG = 5'h00;
	localparam logic [4:0] ADR_GPIO = 5'h02;
	localparam logic [1:0] ADR_DATA_SEL = 2'h1;
	localparam logic [1:0] ADR_ZERO_SEL = 2'h2;
	localparam logic [1:0] ADR_GAIN_SEL = 2'h3;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CFG_LD_BIT = 12;
	localparam int CFG_RST_BIT = 11;
	localparam int CFG_SCE_BIT = 8;
	localparam int CFG_GBF_BIT = 7;
	localparam int GPIO_BIT = 13;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [13:0] CODE_ZERO = 14'h0000;
	localparam logic [13:0] CODE_MID = 14'h2000;
	localparam logic [13:0] OFS_BIN = 14'h2666;
	localparam logic [13:0] OFS_BTC = 14'h0666;
	localparam logic [13:0] OFS_OFF = 14'h0000;
	localparam logic [13:0] GAIN_DEF = 14'h3FFF;
	localparam logic [13:0] ZERO_DEF = 14'h0000;
	localparam logic [13:0] INPUT_DEF = 14'h0000;
	localparam logic GPIO_DEF = 1'b1;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int CORR_TIME_NS = 50;
	localparam int CORR_CYCLES = (CORR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] CORR_LAST = 8'(CORR_CYCLES - 1);

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef logic [DUC_W-1:0] duc_code_t;

	typedef struct packed {
		logic cs_n;
		logic wr;
		logic [DUC_AW-1:0] addr;
		duc_code_t data;
	} duc_bus_t;

	typedef enum logic [1:0] {
		CE_IDLE = 2'b01,
		CE_RUN = 2'b10
	} duc_ce_state_t;

endpackage

/* logic/duc_reset_values.sv */
`timescale 1ns/100ps
module duc_reset_values import duc_pkg::*; (
	// straps
	input wire logic code_format_select,
	input wire logic reset_level_select,
	input wire logic dual_supply,
	// reset values
	output duc_code_t chan_code,
	output duc_code_t ofs_code,
	output logic ofs_en
);

	// binary low or twos-complement high gives code zero
	assign chan_code = (reset_level_select ^ code_format_select) ? CODE_MID : CODE_ZERO;
	assign ofs_code = !dual_supply ? OFS_OFF : (code_format_select ? OFS_BTC : OFS_BIN);
	assign ofs_en = dual_supply;

endmodule // duc_reset_values

/* logic/duc_corr_engine.sv */
`timescale 1ns/100ps
module duc_corr_engine import duc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic flush,
	input wire logic [DUC_CH-1:0] req,
	// result
	output logic busy,
	output logic done,
	output logic [DUC_CHW-1:0] ch
);

	duc_ce_state_t state_q;
	logic [DUC_CH-1:0] pend_q;
	logic [DUC_CH-1:0] done_mask;
	logic [7:0] cnt_q;
	logic [DUC_CHW-1:0] ch_q;
	logic [DUC_CHW-1:0] first;

	always_comb begin
		first = '0;
		for (int i = DUC_CH - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				first = DUC_CHW'(i);
			end
		end
	end

	assign done = (state_q == CE_RUN) && (cnt_q == CORR_LAST);
	assign done_mask = done ? (DUC_CH'(1) << ch_q) : '0;
	assign ch = ch_q;

	// a new request wins over the completion of the same channel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_q <= '0;
		end else if (flush) begin
			pend_q <= '0;
		end else begin
			pend_q <= (pend_q & ~done_mask) | req;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= CE_IDLE;
			cnt_q <= '0;
			ch_q <= '0;
		end else if (flush) begin
			state_q <= CE_IDLE;
			cnt_q <= '0;
		end else begin
			case (state_q)
				CE_IDLE: begin
					if (|pend_q) begin
						state_q <= CE_RUN;
						ch_q <= first;
						cnt_q <= '0;
					end
				end
				CE_RUN: begin
					if (done) begin
						state_q <= CE_IDLE;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				default: state_q <= CE_IDLE;
			endcase
		end
	end

	// busy holds until no channel is pending or running
	assign busy = (state_q == CE_RUN) || (|pend_q);

endmodule // duc_corr_engine

/* logic/duc_update_ctrl.sv */
//Operation
//- gpio output floats when its bit is 1, pulls low when 0.
//- reading the gpio bit returns the present pin level.
//- any reset sets the gpio bit to 1, pin floating.
//- correction running sets busy flag and pulls busy pin low.
//- busy pin released once data registers are all updated.
//- clear low forces outputs cleared with buffers high impedance.
//- clear ignores load strobes; release with strobe high stays cleared until strobe low.
//- strobe held low means clear release restores latch levels at once.
//- clear leaves zero, gain, input, data registers and latches untouched.
//- power-on loads offset, data, latches by select pin; gain, zero defaults.
//- power-on and hardware reset clear input data registers to zero.
//- dual supply reset codes by format and select; offset 2666h or 0666h.
//- single supply disables offset; same reset code mapping.
//- hardware reset low holds registers and latches at reset values.
//- hardware reset ignores bus inputs and floats the data bus.
//- after hardware reset outputs keep reset values; bus resumes.
//- strobe level at power-on picks asynchronous or synchronous mode.
//- load reloads only channels written since previous load.
//- asynchronous mode ignores soft load bit and load strobe.
//- asynchronous, correction off: latch updates at chip select rise.
//- asynchronous, correction on: latch updates when engine writes channel.
//- synchronous load updates all pending latches unless correction busy.
//- synchronous load during busy is deferred until busy clears.
`timescale 1ns/100ps
module duc_update_ctrl import duc_pkg::*; (
	// clock and power-on reset
	input wire logic clk,
	input wire logic rst,
	// control pins
	input wire logic hw_reset_n,
	input wire logic output_clear_n,
	input wire logic latch_load_strobe_n,
	input wire logic reset_level_select,
	input wire logic code_format_select,
	input wire logic dual_supply,
	// parallel bus
	input wire duc_bus_t bus,
	output duc_code_t rd_data,
	output logic rd_oe,
	// open-drain pins
	input wire logic gpio_in,
	output logic gpio_out,
	output logic gpio_oe,
	output logic busy_out,
	output logic busy_oe,
	// converter side
	output duc_code_t [DUC_CH-1:0] latch_code,
	output logic outputs_cleared,
	output duc_code_t offset_code,
	output logic offset_en,
	output logic sync_mode,
	output logic correction_busy_flag
);

	// ----------------------------------------
	// reset sequencing and straps
	// ----------------------------------------
	logic init_q;
	logic sync_q;
	logic bus_live;
	logic soft_rst;
	logic def_load;
	duc_code_t rv_chan;
	duc_code_t rv_ofs;
	logic rv_ofs_en;

	duc_reset_values u_rv (
		.code_format_select(code_format_select),
		.reset_level_select(reset_level_select),
		.dual_supply(dual_supply),
		.chan_code(rv_chan),
		.ofs_code(rv_ofs),
		.ofs_en(rv_ofs_en)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			init_q <= 1'b1;
		end else begin
			init_q <= 1'b0;
		end
	end

	// the strobe pin is caught on the first edge after power-on release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_q <= 1'b0;
		end else if (init_q) begin
			sync_q <= latch_load_strobe_n;
		end
	end

	assign bus_live = hw_reset_n && !init_q;
	assign def_load = init_q || !hw_reset_n || soft_rst;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic cs_prev_q;
	logic cs_rise;
	logic wr_evt;
	logic wr_data;
	logic wr_zero;
	logic wr_gain;
	logic wr_cfg;
	logic wr_gpio;
	logic [DUC_CHW-1:0] wr_ch;
	logic sce_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_prev_q <= 1'b1;
		end else begin
			cs_prev_q <= bus.cs_n;
		end
	end

	// writes take effect on the chip select rising edge
	assign cs_rise = !cs_prev_q && bus.cs_n;
	assign wr_evt = bus_live && cs_rise && bus.wr;
	assign wr_ch = bus.addr[DUC_CHW-1:0];
	assign wr_data = wr_evt && (bus.addr[4:3] == ADR_DATA_SEL);
	assign wr_zero = wr_evt && (bus.addr[4:3] == ADR_ZERO_SEL);
	assign wr_gain = wr_evt && (bus.addr[4:3] == ADR_GAIN_SEL);
	assign wr_cfg = wr_evt && (bus.addr == ADR_CONFIG);
	assign wr_gpio = wr_evt && (bus.addr == ADR_GPIO);
	assign soft_rst = wr_cfg && bus.data[CFG_RST_BIT];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sce_q <= 1'b0;
		end else if (def_load) begin
			sce_q <= 1'b0;
		end else if (wr_cfg) begin
			sce_q <= bus.data[CFG_SCE_BIT];
		end
	end

	// ----------------------------------------
	// correction engine
	// ----------------------------------------
	logic ce_busy;
	logic ce_done;
	logic [DUC_CHW-1:0] ce_ch;
	logic [DUC_CH-1:0] ce_req;
	duc_code_t [DUC_CH-1:0] input_q;
	duc_code_t [DUC_CH-1:0] zero_q;
	duc_code_t [DUC_CH-1:0] gain_q;
	logic [14:0] gain_p1;
	logic [28:0] prod;
	duc_code_t corr;

	assign ce_req = (wr_data && sce_q) ? (DUC_CH'(1) << wr_ch) : '0;

	duc_corr_engine u_ce (
		.clk(clk),
		.rst(rst),
		.flush(def_load),
		.req(ce_req),
		.busy(ce_busy),
		.done(ce_done),
		.ch(ce_ch)
	);

	// full-scale gain of 3fffh passes the code through unchanged
	assign gain_p1 = {1'b0, gain_q[ce_ch]} + 15'h0001;
	assign prod = 29'(input_q[ce_ch]) * 29'(gain_p1);
	assign corr = prod[27:14] + zero_q[ce_ch];

	assign correction_busy_flag = ce_busy;
	assign busy_oe = ce_busy;
	assign busy_out = 1'b0;

	// ----------------------------------------
	// load events
	// ----------------------------------------
	logic strb_prev_q;
	logic strb_fall;
	logic load_req;
	logic defer_q;
	logic fire;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strb_prev_q <= 1'b1;
		end else begin
			strb_prev_q <= latch_load_strobe_n;
		end
	end

	assign strb_fall = strb_prev_q && !latch_load_strobe_n;
	// clear and asynchronous mode both mask the load sources
	assign load_req = sync_q && output_clear_n && bus_live
		&& (strb_fall || (wr_cfg && bus.data[CFG_LD_BIT]));
	assign fire = !def_load && ((load_req && !(sce_q && ce_busy)) || (defer_q && !ce_busy));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			defer_q <= 1'b0;
		end else if (def_load) begin
			defer_q <= 1'b0;
		end else if (load_req && sce_q && ce_busy) begin
			defer_q <= 1'b1;
		end else if (!ce_busy) begin
			defer_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// channel registers and latches
	// ----------------------------------------
	duc_code_t [DUC_CH-1:0] data_q;
	duc_code_t [DUC_CH-1:0] latch_q;
	logic [DUC_CH-1:0] dirty_q;

	for (genvar i = 0; i < DUC_CH; i++) begin : g_ch
		logic host_wr;
		logic eng_wr;
		logic data_wr;
		duc_code_t data_new;

		assign host_wr = wr_data && !sce_q && (wr_ch == DUC_CHW'(i));
		assign eng_wr = ce_done && (ce_ch == DUC_CHW'(i));
		assign data_wr = host_wr || eng_wr;
		assign data_new = host_wr ? bus.data : corr;

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				input_q[i] <= INPUT_DEF;
				zero_q[i] <= ZERO_DEF;
				gain_q[i] <= GAIN_DEF;
			end else if (def_load) begin
				input_q[i] <= INPUT_DEF;
				zero_q[i] <= ZERO_DEF;
				gain_q[i] <= GAIN_DEF;
			end else begin
				if (wr_data && sce_q && wr_ch == DUC_CHW'(i)) begin
					input_q[i] <= bus.data;
				end
				if (wr_zero && wr_ch == DUC_CHW'(i)) begin
					zero_q[i] <= bus.data;
				end
				if (wr_gain && wr_ch == DUC_CHW'(i)) begin
					gain_q[i] <= bus.data;
				end
			end
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				data_q[i] <= CODE_ZERO;
			end else if (def_load) begin
				data_q[i] <= rv_chan;
			end else if (data_wr) begin
				data_q[i] <= data_new;
			end
		end

		// latches see the clear input only through the masked load sources
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				latch_q[i] <= CODE_ZERO;
			end else if (def_load) begin
				latch_q[i] <= rv_chan;
			end else if (!sync_q && data_wr) begin
				latch_q[i] <= data_new;
			end else if (fire && dirty_q[i]) begin
				latch_q[i] <= data_q[i];
			end
		end

		// a write in the firing cycle stays pending for the next load
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				dirty_q[i] <= 1'b0;
			end else if (def_load) begin
				dirty_q[i] <= 1'b0;
			end else if (sync_q && data_wr) begin
				dirty_q[i] <= 1'b1;
			end else if (fire) begin
				dirty_q[i] <= 1'b0;
			end
		end
	end

	assign latch_code = latch_q;

	// ----------------------------------------
	// output clear
	// ----------------------------------------
	logic clr_hold_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clr_hold_q <= 1'b0;
		end else if (!output_clear_n) begin
			clr_hold_q <= 1'b1;
		end else if (!latch_load_strobe_n) begin
			clr_hold_q <= 1'b0;
		end
	end

	assign outputs_cleared = clr_hold_q;

	// ----------------------------------------
	// offset converter
	// ----------------------------------------
	duc_code_t ofs_q;
	logic ofs_en_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ofs_q <= OFS_OFF;
			ofs_en_q <= 1'b0;
		end else if (def_load) begin
			ofs_q <= rv_ofs;
			ofs_en_q <= rv_ofs_en;
		end
	end

	assign offset_code = ofs_q;
	assign offset_en = ofs_en_q;
	assign sync_mode = sync_q;

	// ----------------------------------------
	// general-purpose pin
	// ----------------------------------------
	logic gpio_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gpio_q <= GPIO_DEF;
		end else if (def_load) begin
			gpio_q <= GPIO_DEF;
		end else if (wr_gpio) begin
			gpio_q <= bus.data[GPIO_BIT];
		end
	end

	assign gpio_oe = !gpio_q;
	assign gpio_out = 1'b0;

	// ----------------------------------------
	// read back
	// ----------------------------------------
	duc_code_t rd_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_q <= '0;
		end else begin
			rd_q <= '0;
			case (bus.addr[4:3])
				2'h0: begin
					if (bus.addr == ADR_CONFIG) begin
						rd_q[CFG_SCE_BIT] <= sce_q;
						rd_q[CFG_GBF_BIT] <= ce_busy;
					end else if (bus.addr == ADR_GPIO) begin
						rd_q[GPIO_BIT] <= gpio_in;
					end
				end
				ADR_DATA_SEL: rd_q <= data_q[bus.addr[DUC_CHW-1:0]];
				ADR_ZERO_SEL: rd_q <= zero_q[bus.addr[DUC_CHW-1:0]];
				ADR_GAIN_SEL: rd_q <= gain_q[bus.addr[DUC_CHW-1:0]];
				default: rd_q <= '0;
			endcase
		end
	end

	assign rd_data = rd_q;
	assign rd_oe = bus_live && !bus.cs_n && !bus.wr;

endmodule // duc_update_ctrl

/* tb/duc_update_ctrl_checker.sv */
`timescale 1ns/100ps
module duc_update_ctrl_checker import duc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins
	input wire logic hw_reset_n,
	input wire logic output_clear_n,
	input wire logic latch_load_strobe_n,
	input wire duc_bus_t bus,
	// outputs
	input wire logic gpio_oe,
	input wire logic busy_oe,
	input wire duc_code_t [DUC_CH-1:0] latch_code,
	input wire logic outputs_cleared,
	input wire logic sync_mode,
	input wire logic correction_busy_flag
);
	// ----------------------------------------
	// write decode
	// ----------------------------------------
	logic cs_q;
	logic sce_q;
	logic take;
	assign take = bus.cs_n && !cs_q && bus.wr && hw_reset_n;
	// sce copy is only good while software reset is not combined with sce writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_q <= 1'b1;
			sce_q <= 1'b0;
		end else begin
			cs_q <= bus.cs_n;
			if (!hw_reset_n) begin
				sce_q <= 1'b0;
			end else if (take && bus.addr == ADR_CONFIG) begin
				sce_q <= bus.data[CFG_SCE_BIT];
			end
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	gpio_write_a: assert property (take && bus.addr == ADR_GPIO |=> gpio_oe == !$past(bus.data[GPIO_BIT]))
		else $error("gpio enable wrong");
	hw_gpio_a: assert property (!hw_reset_n |=> !gpio_oe)
		else $error("gpio not released in reset");
	busy_start_a: assert property (take && sce_q && bus.addr[4:3] == ADR_DATA_SEL |-> ##[1:3] (busy_oe && correction_busy_flag))
		else $error("busy not raised");
	busy_end_a: assert property ($rose(busy_oe) |-> ##[1:200] !busy_oe)
		else $error("busy never released");
	clear_force_a: assert property (!output_clear_n |=> outputs_cleared)
		else $error("clear not applied");
	clear_hold_a: assert property (outputs_cleared && latch_load_strobe_n |=> outputs_cleared)
		else $error("clear left early");
	clear_release_a: assert property (output_clear_n && !latch_load_strobe_n |=> !outputs_cleared)
		else $error("clear not left");
	clear_keep_a: assert property (sync_mode && !output_clear_n && hw_reset_n && !take |=> $stable(latch_code))
		else $error("latch moved under clear");
	async_write_a: assert property (!sync_mode && !sce_q && take && bus.addr[4:3] == ADR_DATA_SEL
		|=> latch_code[$past(bus.addr[2:0])] == $past(bus.data))
		else $error("async latch not written");
	sync_hold_a: assert property (sync_mode && hw_reset_n && !take && latch_load_strobe_n && !busy_oe
		&& !$past(busy_oe) |=> $stable(latch_code))
		else $error("latch moved without load");
	cover property ($fell(latch_load_strobe_n) && busy_oe);
	cover property ($fell(outputs_cleared));
	cover property (take && bus.addr == ADR_CONFIG && bus.data[CFG_LD_BIT]);
endmodule // duc_update_ctrl_checker

bind duc_update_ctrl duc_update_ctrl_checker chk (.clk(clk), .rst(rst), .hw_reset_n(hw_reset_n),
	.output_clear_n(output_clear_n), .latch_load_strobe_n(latch_load_strobe_n), .bus(bus), .gpio_oe(gpio_oe),
	.busy_oe(busy_oe), .latch_code(latch_code), .outputs_cleared(outputs_cleared), .sync_mode(sync_mode),
	.correction_busy_flag(correction_busy_flag));

/* tb/duc_host.sv */
`timescale 1ns/100ps
module duc_host import duc_pkg::*; (
	// clock
	input wire logic clk,
	// parallel bus
	output duc_bus_t bus,
	input wire duc_code_t rd_data
);
	logic act = 1'b0;
	initial begin
		bus = '{cs_n: 1'b1, wr: 1'b0, addr: 5'h00, data: 14'h0000};
	end
	// idle data keeps changing so a stale sample cannot match
	always @(posedge clk) begin
		if (!act) begin
			bus.data <= ~bus.data;
		end
	end
	task automatic wr(input logic [4:0] a, input duc_code_t d);
		@(posedge clk);
		#1;
		act = 1'b1;
		bus = '{cs_n: 1'b0, wr: 1'b1, addr: a, data: d};
		@(posedge clk);
		#1;
		bus.cs_n = 1'b1;
		@(posedge clk);
		#1;
		bus.wr = 1'b0;
		act = 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output duc_code_t d);
		@(posedge clk);
		#1;
		bus.cs_n = 1'b0;
		bus.addr = a;
		@(posedge clk);
		#1;
		// read data is registered, so it is taken once it has settled after the edge
		d = rd_data;
		@(posedge clk);
		#1;
		bus.cs_n = 1'b1;
	endtask
endmodule // duc_host

/* tb/duc_update_ctrl_tb.sv */
`timescale 1ns/100ps
module duc_update_ctrl_tb import duc_pkg::*;;
	logic clk = 0, rst = 1, hw_reset_n = 1, output_clear_n = 1, latch_load_strobe_n = 1;
	logic reset_level_select = 0, code_format_select = 0, dual_supply = 1, ext_low = 0;
	logic rd_oe, gpio_out, gpio_oe, busy_out, busy_oe, outputs_cleared, offset_en, sync_mode, correction_busy_flag;
	duc_bus_t bus;
	duc_code_t rd_data, offset_code, v;
	duc_code_t [DUC_CH-1:0] latch_code;
	wire gpio_pin;
	int mismatches = 0, n_compared = 0, cyc = 0, seed = 69317, mode_sync = 1;
	int lat[8], dat[8], pend[8];
	// pull-up pin, low when either side pulls down
	assign gpio_pin = ((gpio_oe && !gpio_out) || ext_low) ? 1'b0 : 1'b1;
	always #2.5 clk = ~clk;
	duc_update_ctrl dut (.clk(clk), .rst(rst), .hw_reset_n(hw_reset_n), .output_clear_n(output_clear_n),
		.latch_load_strobe_n(latch_load_strobe_n), .reset_level_select(reset_level_select),
		.code_format_select(code_format_select), .dual_supply(dual_supply), .bus(bus), .rd_data(rd_data),
		.rd_oe(rd_oe), .gpio_in(gpio_pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .busy_out(busy_out),
		.busy_oe(busy_oe), .latch_code(latch_code), .outputs_cleared(outputs_cleared), .offset_code(offset_code),
		.offset_en(offset_en), .sync_mode(sync_mode), .correction_busy_flag(correction_busy_flag));
	duc_host host (.clk(clk), .bus(bus), .rd_data(rd_data));
	// ----------------------------------------
	// model and helpers
	// ----------------------------------------
	task test_done();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			test_done();
		end
	end
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task mreset();
		for (int i = 0; i < 8; i++) begin
			lat[i] = (reset_level_select ^ code_format_select) ? 'h2000 : 0;
			dat[i] = lat[i];
			pend[i] = 0;
		end
	endtask
	task mwrite(input int ch, input duc_code_t d);
		host.wr(5'(8 + ch), d);
		dat[ch] = d;
		pend[ch] = mode_sync;
		if (mode_sync == 0) begin
			lat[ch] = d;
		end
	endtask
	task mload();
		for (int i = 0; i < 8; i++) begin
			if (pend[i] != 0) begin
				lat[i] = dat[i];
			end
			pend[i] = 0;
		end
	endtask
	task check_lat();
		for (int i = 0; i < 8; i++) begin
			chk("latch", 16'(lat[i]), latch_code[i]);
		end
	endtask
	task pulse();
		latch_load_strobe_n = 0;
		tick(2);
		latch_load_strobe_n = 1;
	endtask
	task wait_idle();
		tick(2);
		for (int i = 0; i < 40 && busy_oe !== 1'b0; i++) begin
			tick(1);
		end
		tick(1);
	endtask
	task por(input logic sn, input logic rs, input logic fm, input logic du);
		rst = 1;
		latch_load_strobe_n = sn;
		reset_level_select = rs;
		code_format_select = fm;
		dual_supply = du;
		mode_sync = sn;
		tick(3);
		rst = 0;
		tick(2);
		mreset();
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		for (int k = 0; k < 8; k++) begin
			por(1'b1, k[0], k[1], k[2]);
			check_lat();
			chk("ofs_en", 16'(k[2]), offset_en);
			if (k[2]) begin
				chk("ofs", k[1] ? 16'h0666 : 16'h2666, offset_code);
			end else begin
				chk("ofs", 16'h0000, offset_code);
			end
			chk("gpio_oe", 16'h0000, gpio_oe);
			chk("mode", 16'h0001, sync_mode);
		end
		v = 14'($random(seed));
		mwrite(2, v);
		mwrite(5, ~v);
		check_lat();
		pulse();
		mload();
		check_lat();
		mwrite(3, v ^ 14'h1555);
		host.wr(ADR_CONFIG, 14'h1000);
		mload();
		check_lat();
		output_clear_n = 0;
		mwrite(1, ~v);
		pulse();
		chk("cleared", 16'h0001, outputs_cleared);
		check_lat();
		output_clear_n = 1;
		tick(3);
		chk("cleared", 16'h0001, outputs_cleared);
		pulse();
		mload();
		chk("cleared", 16'h0000, outputs_cleared);
		check_lat();
		host.wr(ADR_GPIO, 14'h0000);
		chk("gpio_oe", 16'h0001, gpio_oe);
		chk("gpio_out", 16'h0000, gpio_out);
		fork
			host.rd(ADR_GPIO, v);
			begin
				tick(2);
				chk("rd_oe", 16'h0001, rd_oe);
			end
		join
		chk("gpio_rd", 16'h0000, v[GPIO_BIT]);
		host.wr(ADR_GPIO, 14'h2000);
		chk("gpio_oe", 16'h0000, gpio_oe);
		for (int b = 0; b < 2; b++) begin
			ext_low = b[0];
			host.rd(ADR_GPIO, v);
			chk("gpio_rd", 16'(!b[0]), v[GPIO_BIT]);
		end
		ext_low = 0;
		host.wr(ADR_GPIO, 14'h0000);
		host.wr(ADR_CONFIG, 14'h0800);
		mreset();
		chk("gpio_oe", 16'h0000, gpio_oe);
		host.wr(ADR_GPIO, 14'h0000);
		v = 14'($random(seed));
		mwrite(0, v);
		hw_reset_n = 0;
		tick(3);
		mreset();
		check_lat();
		chk("gpio_oe", 16'h0000, gpio_oe);
		hw_reset_n = 1;
		host.wr(ADR_CONFIG, 14'h1000);
		check_lat();
		mwrite(4, v);
		pulse();
		mload();
		check_lat();
		host.wr(ADR_CONFIG, 14'h0100);
		mwrite(6, ~v);
		tick(1);
		chk("busy", 16'h0001, correction_busy_flag);
		chk("busy_oe", 16'h0001, busy_oe);
		chk("busy_out", 16'h0000, busy_out);
		host.rd(ADR_CONFIG, v);
		chk("cfg_rd", 16'h0180, v);
		pulse();
		check_lat();
		wait_idle();
		chk("busy_oe", 16'h0000, busy_oe);
		mload();
		check_lat();
		host.wr(ADR_CONFIG, 14'h0000);
		por(1'b0, 1'b0, 1'b0, 1'b1);
		chk("mode", 16'h0000, sync_mode);
		mwrite(4, v);
		check_lat();
		// the strap is low here, so make a real falling edge for the device to ignore
		latch_load_strobe_n = 1;
		tick(2);
		latch_load_strobe_n = 0;
		tick(2);
		host.wr(ADR_CONFIG, 14'h1000);
		check_lat();
		host.wr(ADR_CONFIG, 14'h0100);
		mwrite(7, ~v);
		wait_idle();
		check_lat();
		test_done();
	end
endmodule // duc_update_ctrl_tb
